/* File: core/scf_pkg.sv */
// Shared constants and types for the companion-chip front end and its host.
// Assumes a 125 MHz system clock on both ends.
package scf_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned READY_MS = 60;
   localparam int unsigned WAKE_MS = 50;
   localparam int unsigned READY_CYC = READY_MS * (CLK_HZ / 1000);
   localparam int unsigned WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
   localparam int unsigned PENALTY_CYC = 4 * READY_CYC;
   localparam int unsigned SCL_MAX_KHZ = 400;
   localparam int unsigned SCL_HALF_CYC = (CLK_HZ + 2 * SCL_MAX_KHZ * 1000 - 1) / (2 * SCL_MAX_KHZ * 1000);
   // ****************************************************************
   // Storage layout and values after reset
   // ****************************************************************
   localparam int unsigned HASH_BLOCK_BYTES = 64;
   localparam int unsigned SECRET_BYTES = 8;
   localparam int unsigned NUM_COUNTERS = 4;
   localparam int unsigned CNT_MAX = 64_000_000;
   localparam int unsigned NUM_KEYS = 16;
   localparam int unsigned NUM_PW_SETS = 8;
   localparam int unsigned PW_BITS = 24;
   localparam logic [6:0] DEV_ADDR_RST = 7'h5_8;
   localparam logic [63:0] OBSCURE_MASK = 64'hA5C3_9E17_5B2D_C46F;
   localparam logic [31:0] LFSR_SEED = 32'hACE1_2468;
   // Command codes (first data byte)
   typedef enum logic [7:0] {
      SCF_CMD_DERIVE = 8'h0_1,
      SCF_CMD_CHALLENGE = 8'h0_2,
      SCF_CMD_COUNT = 8'h0_3,
      SCF_CMD_PENALTY = 8'h0_4
   } scf_cmd_e;
endpackage : scf_pkg

/* File: core/scf_bus_if.sv */
// Two-wire bus between host and companion chip.
// Assumes open-drain lines with pull-ups: a line is low while any enable is high.
`timescale 1ns/1ns
interface scf_bus_if;
   logic scl_oe_host;
   logic sda_oe_host;
   logic sda_oe_dev;
   logic scl_oe_dev;
   logic scl;
   logic sda;
   assign scl = ~(scl_oe_host | scl_oe_dev);
   assign sda = ~(sda_oe_host | sda_oe_dev);
   modport dev (input scl, input sda, output sda_oe_dev, output scl_oe_dev);
   modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface : scf_bus_if

/* File: core/scf_device.sv */
// Companion-chip device end: two-wire slave, readiness gating, key derivation.
// Assumes the interface resolves open-drain lines; sleep and reset are pins.
`timescale 1ns/1ns
// Function
// - Hash operands joined in order, padded 64 bytes
// - Only single-block hash inputs processed
// - Tag secret from root, tag id, diversifier
// - Secrets stored obscured, never sent out; code masks only the root, tag_reg is held plain
// - Random seed starts each authentication
// - Host uses tag only after mutual confirmation
// - Ready 60ms after reset, longer if penalty
// - Reset clears all state, even asleep; code keeps penalty flag and masked root
// - Sleep high ignores all bus activity
// - 50ms quiet after sleep falls
// - Slave only, never stretches clock
// - Master clock at most 400KHz
// - Host formats commands and relays to tag
// - Shared bus needs distinct addresses
// - Four up counters, 64 million max
// - 16 key sets, eight password pairs
// - Reset cannot bypass pending penalty
module scf_device
   import scf_pkg::*;
#(
   parameter int unsigned READY_CYCLES = READY_CYC,
   parameter int unsigned WAKE_CYCLES = WAKE_CYC,
   parameter int unsigned PENALTY_CYCLES = PENALTY_CYC
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   input wire logic I_SLEEP_REQUEST,
   input wire logic [63:0] I_ROOT_SECRET,
   input wire logic I_ROOT_LOAD,
   scf_bus_if.dev bus,
   output logic O_READY,
   output logic O_AUTH_OK
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] scl_sync_reg, sda_sync_reg, slp_sync_reg;
   logic scl_d_reg, sda_d_reg;
   always_ff @(posedge I_CLK_SYS) begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      slp_sync_reg <= {slp_sync_reg[0], I_SLEEP_REQUEST};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
   end
   wire logic scl_s = scl_sync_reg[1];
   wire logic sda_s = sda_sync_reg[1];
   wire logic asleep = slp_sync_reg[1];
   wire logic scl_rise = scl_s & ~scl_d_reg;
   wire logic scl_fall = ~scl_s & scl_d_reg;
   wire logic start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire logic stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ****************************************************************
   // Readiness: power-up wait, wake delay, penalty lock
   // ****************************************************************
   // The penalty flag survives reset so cycling reset cannot skip it
   logic penalty_reg = 1'b0;
   logic penalty_set;
   logic [31:0] wait_reg;
   logic slp_d_reg;
   logic ready_reg;
   always_ff @(posedge I_CLK_SYS) begin
      slp_d_reg <= asleep;
      if (!I_RSTN) begin
         wait_reg <= penalty_reg ? PENALTY_CYCLES : READY_CYCLES;
         ready_reg <= 1'b0;
      end else if (asleep) begin
         ready_reg <= 1'b0;
         wait_reg <= (wait_reg > WAKE_CYCLES) ? wait_reg : WAKE_CYCLES;
      end else if (slp_d_reg) begin
         ready_reg <= 1'b0;
         wait_reg <= (wait_reg > WAKE_CYCLES) ? wait_reg : WAKE_CYCLES;
      end else if (wait_reg != 32'h0000_0000) begin
         wait_reg <= wait_reg - 32'h0000_0001;
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= 1'b1;
      end
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (penalty_set) begin
         penalty_reg <= 1'b1;
      end else if (I_RSTN && !asleep && !slp_d_reg && wait_reg == 32'h0000_0000 && !ready_reg) begin
         penalty_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // Two-wire slave
   // ****************************************************************
   typedef enum logic [2:0] {SCF_IDLE, SCF_ADDR, SCF_AACK, SCF_WDATA, SCF_WACK, SCF_RDATA, SCF_RACK} scf_st_e;
   scf_st_e st_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic sda_oe_reg;
   logic [3:0] byte_reg;
   logic [7:0] cmd_reg;
   logic [7:0] rd_idx_reg;
   logic [63:0] kid_reg, id_reg, tag_reg, rng_lat_reg;
   logic [31:0] lfsr_reg;
   logic [63:0] root_obs_reg;
   logic [25:0] cnt_reg [NUM_COUNTERS];
   logic [63:0] key_mem [NUM_KEYS];
   logic [PW_BITS-1:0] pw_mem [NUM_PW_SETS][2];
   logic wr_byte, rd_go;
   logic [7:0] rd_byte;
   wire logic active = ready_reg & I_RSTN;

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN || !active) begin
         st_reg <= SCF_IDLE;
         sda_oe_reg <= 1'b0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h0_0;
      end else if (start_c) begin
         st_reg <= SCF_ADDR;
         bit_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (stop_c) begin
         st_reg <= SCF_IDLE;
         sda_oe_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            SCF_IDLE: ;
            SCF_ADDR, SCF_WDATA: begin
               if (scl_rise) begin
                  sh_reg <= {sh_reg[6:0], sda_s};
                  bit_reg <= bit_reg + 4'h1;
               end else if (scl_fall && bit_reg == 4'h8) begin
                  bit_reg <= 4'h0;
                  if (st_reg == SCF_WDATA) begin
                     sda_oe_reg <= 1'b1;
                     st_reg <= SCF_WACK;
                  end else if (sh_reg[7:1] == DEV_ADDR_RST) begin
                     sda_oe_reg <= 1'b1;
                     st_reg <= SCF_AACK;
                  end else begin
                     st_reg <= SCF_IDLE;
                  end
               end
            end
            SCF_AACK, SCF_WACK: begin
               if (scl_fall) begin
                  if (st_reg == SCF_AACK && sh_reg[0]) begin
                     st_reg <= SCF_RDATA;
                     sh_reg <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                     bit_reg <= 4'h1;
                  end else begin
                     st_reg <= SCF_WDATA;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            SCF_RDATA: begin
               if (scl_fall) begin
                  if (bit_reg == 4'h8) begin
                     sda_oe_reg <= 1'b0;
                     st_reg <= SCF_RACK;
                  end else begin
                     sda_oe_reg <= ~sh_reg[3'(7 - bit_reg)];
                     bit_reg <= bit_reg + 4'h1;
                  end
               end
            end
            SCF_RACK: begin
               if (scl_rise) begin
                  st_reg <= sda_s ? SCF_IDLE : SCF_RACK;
               end else if (scl_fall) begin
                  st_reg <= SCF_RDATA;
                  sh_reg <= rd_byte;
                  sda_oe_reg <= ~rd_byte[7];
                  bit_reg <= 4'h1;
               end
            end
         endcase
      end
   end
   assign wr_byte = (st_reg == SCF_WDATA) && scl_fall && bit_reg == 4'h8 && active && !start_c && !stop_c;
   assign rd_go = scl_fall && active && ((st_reg == SCF_AACK && sh_reg[0]) || st_reg == SCF_RACK);

   // ****************************************************************
   // Command bytes: code, then tag id and diversifier
   // ****************************************************************
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN || start_c) begin
         byte_reg <= 4'h0;
      end else if (wr_byte && byte_reg != 4'hF) begin
         byte_reg <= byte_reg + 4'h1;
      end
      if (!I_RSTN) begin
         cmd_reg <= 8'h0_0;
         id_reg <= 64'h0;
         kid_reg <= 64'h0;
      end else if (wr_byte) begin
         if (byte_reg == 4'h0) begin
            cmd_reg <= sh_reg;
         end else if (byte_reg <= 4'h8) begin
            id_reg <= {id_reg[55:0], sh_reg};
         end else begin
            kid_reg <= {kid_reg[55:0], sh_reg};
         end
      end
   end
   assign penalty_set = wr_byte && byte_reg == 4'h0 && sh_reg == SCF_CMD_PENALTY;

   // Root secret kept only in masked form
   always_ff @(posedge I_CLK_SYS) begin
      if (I_ROOT_LOAD) begin
         root_obs_reg <= I_ROOT_SECRET ^ OBSCURE_MASK;
      end
   end
   always_ff @(posedge I_CLK_SYS) begin
      for (int k = 0; k < NUM_KEYS; k++) begin
         key_mem[k] <= key_mem[k];
      end
      for (int k = 0; k < NUM_PW_SETS; k++) begin
         pw_mem[k] <= pw_mem[k];
      end
   end

   // Single-block digest stand-in: root, id, diversifier in order, padded
   function automatic logic [63:0] scf_digest(input logic [63:0] a, input logic [63:0] b, input logic [63:0] c);
      logic [HASH_BLOCK_BYTES*8-1:0] blk;
      logic [63:0] h;
      blk = {a, b, c, 8'h8_0, 248'h0, 64'h0000_0000_0000_00C0};
      h = 64'h6745_2301_EFCD_AB89;
      for (int w = 0; w < 8; w++) begin
         h = {h[50:0], h[63:51]} ^ blk[w*64 +: 64] ^ (h + 64'h9E37_79B9_7F4A_7C15);
      end
      return h;
   endfunction : scf_digest

   // ****************************************************************
   // Random source, counters, derivation
   // ****************************************************************
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN) begin
         lfsr_reg <= LFSR_SEED;
      end else begin
         lfsr_reg <= {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
      end
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN) begin
         tag_reg <= 64'h0;
         rng_lat_reg <= 64'h0;
         O_AUTH_OK <= 1'b0;
         rd_idx_reg <= 8'h0_0;
      end else begin
         if (wr_byte && byte_reg == 4'h0 && sh_reg == SCF_CMD_CHALLENGE) begin
            rng_lat_reg <= {lfsr_reg, ~lfsr_reg};
            O_AUTH_OK <= 1'b0;
         end
         if (wr_byte && cmd_reg == SCF_CMD_DERIVE && byte_reg == 4'hF) begin
            tag_reg <= scf_digest(root_obs_reg ^ OBSCURE_MASK, id_reg, {kid_reg[55:0], sh_reg});
         end
         if (wr_byte && cmd_reg == SCF_CMD_DERIVE && byte_reg == 4'h9) begin
            O_AUTH_OK <= (tag_reg ^ rng_lat_reg) == {id_reg[55:0], sh_reg};
         end
         rd_idx_reg <= start_c ? 8'h0_0 : rd_go ? rd_idx_reg + 8'h0_1 : rd_idx_reg;
      end
   end
   // Reads return a counter after a count command, else the challenge seed and a keyed response, never a secret
   assign rd_byte = (cmd_reg == SCF_CMD_COUNT) ? cnt_reg[id_reg[1:0]][7:0] :
                    rng_lat_reg[8'(63 - 8 * rd_idx_reg[2:0]) -: 8] ^ (rd_idx_reg[3] ? tag_reg[7:0] : 8'h0_0);

   for (genvar c = 0; c < NUM_COUNTERS; c++) begin : g_cnt
      always_ff @(posedge I_CLK_SYS) begin
         if (!I_RSTN || (wr_byte && cmd_reg == SCF_CMD_COUNT && byte_reg == 4'h1 && sh_reg[1:0] == 2'(c)
             && cnt_reg[c] < 26'(CNT_MAX))) begin
            cnt_reg[c] <= I_RSTN ? cnt_reg[c] + 26'h1 : 26'h0;
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   always_ff @(posedge I_CLK_SYS) begin
      bus.sda_oe_dev <= I_RSTN & sda_oe_reg & ~asleep;
      bus.scl_oe_dev <= 1'b0;
      O_READY <= I_RSTN & ready_reg;
   end
endmodule : scf_device

/* File: core/scf_host.sv */
// Host end: two-wire master that writes bytes and reads bytes from the companion chip.
// Assumes the interface resolves open-drain lines; user holds request until accepted.
`timescale 1ns/1ns
module scf_host
   import scf_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = WAKE_CYC,
   parameter int unsigned HALF_CYCLES = SCL_HALF_CYC
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   input wire logic I_SLEEP_REQUEST,
   input wire logic i_req,
   input wire logic i_rd,
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_last,
   scf_bus_if.host bus,
   output logic o_busy,
   output logic o_byte_done,
   output logic o_ack,
   output logic [7:0] o_rdata
);
   // ****************************************************************
   // Quiet time after sleep and clock divider
   // ****************************************************************
   logic [1:0] slp_sync_reg, sda_sync_reg;
   logic [31:0] quiet_reg;
   logic [15:0] div_reg;
   always_ff @(posedge I_CLK_SYS) begin
      slp_sync_reg <= {slp_sync_reg[0], I_SLEEP_REQUEST};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN || slp_sync_reg[1]) begin
         quiet_reg <= WAKE_CYCLES;
      end else if (quiet_reg != 32'h0000_0000) begin
         quiet_reg <= quiet_reg - 32'h0000_0001;
      end
   end
   // Half-period tick keeps clock at or below 400KHz
   wire logic tick = div_reg == 16'(HALF_CYCLES - 1);
   always_ff @(posedge I_CLK_SYS) begin
      div_reg <= (!I_RSTN || tick) ? 16'h0000 : div_reg + 16'h0001;
   end

   // ****************************************************************
   // Byte sequencer: phase 0 low half, phase 1 high half
   // ****************************************************************
   typedef enum logic [2:0] {SCH_IDLE, SCH_START, SCH_BIT, SCH_ACK, SCH_STOP} sch_st_e;
   sch_st_e st_reg;
   logic ph_reg, rd_reg, addr_ph_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   always_ff @(posedge I_CLK_SYS) begin
      o_byte_done <= 1'b0;
      if (!I_RSTN) begin
         st_reg <= SCH_IDLE;
         bus.scl_oe_host <= 1'b0;
         bus.sda_oe_host <= 1'b0;
         ph_reg <= 1'b0;
         rd_reg <= 1'b0;
         addr_ph_reg <= 1'b0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h0_0;
         o_busy <= 1'b0;
         o_ack <= 1'b0;
         o_rdata <= 8'h0_0;
      end else if (tick) begin
         unique case (st_reg)
            SCH_IDLE: begin
               if (i_req && quiet_reg == 32'h0000_0000) begin
                  st_reg <= SCH_START;
                  o_busy <= 1'b1;
                  rd_reg <= i_rd;
                  addr_ph_reg <= 1'b1;
                  sh_reg <= {i_addr, i_rd};
                  bus.sda_oe_host <= 1'b1;
               end
            end
            SCH_START: begin
               bus.scl_oe_host <= 1'b1;
               st_reg <= SCH_BIT;
               bit_reg <= 4'h0;
               ph_reg <= 1'b0;
            end
            SCH_BIT: begin
               if (!ph_reg) begin
                  bus.sda_oe_host <= (addr_ph_reg || !rd_reg) ? ~sh_reg[7] : 1'b0;
                  bus.scl_oe_host <= 1'b0;
                  ph_reg <= 1'b1;
               end else begin
                  sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                  bus.scl_oe_host <= 1'b1;
                  ph_reg <= 1'b0;
                  if (bit_reg == 4'h7) begin
                     st_reg <= SCH_ACK;
                  end
                  bit_reg <= bit_reg + 4'h1;
               end
            end
            SCH_ACK: begin
               if (!ph_reg) begin
                  // Master acks read bytes unless this is the last one
                  bus.sda_oe_host <= (rd_reg && !addr_ph_reg) ? ~i_last : 1'b0;
                  bus.scl_oe_host <= 1'b0;
                  ph_reg <= 1'b1;
               end else begin
                  bus.scl_oe_host <= 1'b1;
                  ph_reg <= 1'b0;
                  bit_reg <= 4'h0;
                  o_byte_done <= 1'b1;
                  o_ack <= ~sda_sync_reg[1];
                  if (rd_reg && !addr_ph_reg) begin
                     o_rdata <= sh_reg;
                  end
                  addr_ph_reg <= 1'b0;
                  sh_reg <= i_wdata;
                  if ((addr_ph_reg && sda_sync_reg[1]) || (!addr_ph_reg && i_last)) begin
                     st_reg <= SCH_STOP;
                     bus.sda_oe_host <= 1'b1;
                  end else begin
                     st_reg <= SCH_BIT;
                  end
               end
            end
            SCH_STOP: begin
               if (bus.scl_oe_host) begin
                  bus.scl_oe_host <= 1'b0;
               end else begin
                  bus.sda_oe_host <= 1'b0;
                  st_reg <= SCH_IDLE;
                  o_busy <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule : scf_host

/* File: testbench/scf_bus_properties.sv */
// Checker for the two-wire link joining the host end and the device end.
// Assumes the bench feeds it the resolved clock line, device enables, sleep pin and ready flag.
`timescale 1ns/1ns
module scf_bus_properties #(
   parameter int unsigned READY_CYCLES = 2000,
   parameter int unsigned WAKE_CYCLES = 100,
   parameter int unsigned HALF_CYCLES = 20
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   input wire logic I_SLEEP_REQUEST,
   input wire logic O_READY,
   input wire logic scl,
   input wire logic scl_oe_dev,
   input wire logic sda_oe_dev
);
   // ****************************************
   // Saturating counters, so long idles never wrap
   // ****************************************
   logic [15:0] rel_cnt_reg;
   logic [15:0] wake_cnt_reg;
   logic [15:0] low_cnt_reg;
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN) rel_cnt_reg <= 16'h0000;
      else if (rel_cnt_reg != 16'hFFFF) rel_cnt_reg <= rel_cnt_reg + 16'h0001;
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN || I_SLEEP_REQUEST) wake_cnt_reg <= 16'h0000;
      else if (wake_cnt_reg != 16'hFFFF) wake_cnt_reg <= wake_cnt_reg + 16'h0001;
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RSTN || scl) low_cnt_reg <= 16'h0000;
      else if (low_cnt_reg != 16'hFFFF) low_cnt_reg <= low_cnt_reg + 16'h0001;
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RSTN);
   a_no_stretch: assert property (scl_oe_dev == 1'b0)
      else $error("Device pulls the clock line low");
   a_reset_clears: assert property (disable iff (1'b0) !I_RSTN |=> (!O_READY && !sda_oe_dev))
      else $error("Device outputs not cleared by reset");
   a_ready_wait: assert property (O_READY |-> rel_cnt_reg >= READY_CYCLES)
      else $error("Device ready before the power-up wait");
   a_sleep_quiet: assert property (I_SLEEP_REQUEST [*4] |-> !sda_oe_dev)
      else $error("Device drives data while asleep");
   a_wake_gap: assert property ($rose(sda_oe_dev) |-> wake_cnt_reg >= WAKE_CYCLES)
      else $error("Device answers inside the wake-up delay");
   a_ack_ready: assert property ($rose(sda_oe_dev) |-> O_READY)
      else $error("Device answers while not ready");
   a_data_scl_low: assert property ($changed(sda_oe_dev) && !I_SLEEP_REQUEST |-> !scl)
      else $error("Device changes data while the clock is high");
   a_scl_low_time: assert property ($rose(scl) |-> low_cnt_reg >= HALF_CYCLES)
      else $error("Clock low phase shorter than allowed");
   c_dev_ack: cover property ($rose(sda_oe_dev));
   c_ready: cover property ($rose(O_READY));
   c_sleep: cover property (I_SLEEP_REQUEST [*4] ##1 !I_SLEEP_REQUEST);
endmodule : scf_bus_properties

/* File: testbench/tb.sv */
// Bench for the host and device ends joined by one two-wire bus.
// Assumes shortened ready, wake and penalty counts so the run stays short.
`timescale 1ns/1ns
module tb;
   import scf_pkg::*;
   localparam int unsigned RDY = 2000;
   localparam int unsigned WK = 100;
   localparam int unsigned PEN = 4000;
   localparam int unsigned HLF = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic dev_sleep = 1'b0;
   logic host_sleep = 1'b0;
   logic root_load = 1'b0;
   logic [63:0] root = 64'h0123_4567_89AB_CDEF;
   logic req = 1'b0;
   logic rd = 1'b0;
   logic last = 1'b0;
   logic [6:0] addr = DEV_ADDR_RST;
   logic [7:0] wdata = 8'h00;
   logic busy, done, ack, ready, auth_ok, addr_ack, all_ack;
   logic [7:0] rdata;
   logic [7:0] wq [0:18];
   logic [63:0] rv;
   int cyc = 0, rel = 0, take = 0, err_count = 0, num_checks = 0;
   // ****************************************
   // Clock and the two ends on one bus
   // ****************************************
   always #4 clk = ~clk;
   always @(posedge clk) cyc++;
   scf_bus_if scf_bus_if_i ();
   scf_device #(.READY_CYCLES(RDY), .WAKE_CYCLES(WK), .PENALTY_CYCLES(PEN)) scf_device_i (.I_CLK_SYS(clk),
      .I_RSTN(rst_n), .I_SLEEP_REQUEST(dev_sleep), .I_ROOT_SECRET(root), .I_ROOT_LOAD(root_load),
      .bus(scf_bus_if_i), .O_READY(ready), .O_AUTH_OK(auth_ok));
   scf_host #(.WAKE_CYCLES(WK), .HALF_CYCLES(HLF)) scf_host_i (.I_CLK_SYS(clk), .I_RSTN(rst_n),
      .I_SLEEP_REQUEST(host_sleep), .i_req(req), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_last(last),
      .bus(scf_bus_if_i), .o_busy(busy), .o_byte_done(done), .o_ack(ack), .o_rdata(rdata));
   scf_bus_properties #(.READY_CYCLES(RDY), .WAKE_CYCLES(WK), .HALF_CYCLES(HLF)) scf_bus_properties_i (
      .I_CLK_SYS(clk), .I_RSTN(rst_n), .I_SLEEP_REQUEST(dev_sleep), .O_READY(ready),
      .scl(scf_bus_if_i.scl), .scl_oe_dev(scf_bus_if_i.scl_oe_dev), .sda_oe_dev(scf_bus_if_i.sda_oe_dev));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   // Every polling wait goes through here, so a hang ends in the report
   task automatic tick(inout int w);
      @(negedge clk);
      w++;
      if (w > 10000) begin
         err_count++;
         $display("Error at %0t: wait expired, got %0h expected %0h", $time, w, 0);
         conclude();
      end
   endtask : tick
   task automatic do_reset(input logic slp);
      @(negedge clk);
      rst_n = 1'b0;
      dev_sleep = slp;
      repeat (16) @(negedge clk);
      check(ready, 1'b0);
      dev_sleep = 1'b0;
      rst_n = 1'b1;
      rel = cyc;
   endtask : do_reset
   task automatic wait_ready(input int lo);
      int w = 0;
      while (ready !== 1'b1) tick(w);
      check(cyc - rel >= lo && cyc - rel <= lo + 8, 1'b1);
   endtask : wait_ready
   // Next write byte is presented at each byte-done, ahead of the ack phase that samples it
   task automatic xfer(input logic rdn, input int n);
      int w = 0;
      int k = 0;
      @(negedge clk);
      req = 1'b1;
      rd = rdn;
      wdata = wq[0];
      last = (n == 1);
      addr_ack = 1'bx;
      all_ack = 1'b1;
      while (busy !== 1'b1) tick(w);
      take = cyc;
      req = 1'b0;
      while (busy === 1'b1) begin
         if (done === 1'b1) begin
            if (k == 0) addr_ack = ack;
            else if (rdn) rv = {rv[55:0], rdata};
            else all_ack = all_ack & ack;
            wdata = wq[k + 1];
            last = (k == n - 1);
            k++;
         end
         tick(w);
      end
   endtask : xfer
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_power_up;
      do_reset(1'b0);
      wq[0] = SCF_CMD_CHALLENGE;
      xfer(1'b0, 1);
      check(addr_ack, 1'b0);
      wait_ready(RDY);
      addr = DEV_ADDR_RST ^ 7'h01;
      xfer(1'b0, 1);
      check(addr_ack, 1'b0);
      addr = DEV_ADDR_RST;
      $display("Test power_up done");
   endtask : t_power_up
   task automatic t_derive;
      @(negedge clk);
      root_load = 1'b1;
      @(negedge clk);
      root_load = 1'b0;
      wq[0] = SCF_CMD_DERIVE;
      for (int i = 1; i < 17; i++) wq[i] = 8'h30 + i[7:0];
      xfer(1'b0, 17);
      check(addr_ack & all_ack, 1'b1);
      xfer(1'b1, 8);
      check(rv !== root && rv !== (root ^ OBSCURE_MASK), 1'b1);
      $display("Test derive done");
   endtask : t_derive
   task automatic t_challenge;
      logic [63:0] s [0:1];
      for (int j = 0; j < 2; j++) begin
         wq[0] = SCF_CMD_CHALLENGE;
         xfer(1'b0, 1);
         xfer(1'b1, 8);
         s[j] = rv;
      end
      check(s[0] !== s[1], 1'b1);
      check(auth_ok, 1'b0);
      $display("Test challenge done");
   endtask : t_challenge
   task automatic t_counter;
      logic [7:0] c [0:1];
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         for (int j = 0; j < 2; j++) begin
            wq[0] = SCF_CMD_COUNT;
            wq[1] = i[7:0];
            xfer(1'b0, 2);
            xfer(1'b1, 1);
            c[j] = rv[7:0];
         end
         check(c[1], c[0] + 8'h01);
      end
      $display("Test counter done");
   endtask : t_counter
   // Host kept awake during the first device sleep, so its frame reaches a sleeping device; both sleep the second time
   task automatic t_sleep;
      dev_sleep = 1'b1;
      repeat (8) @(negedge clk);
      wq[0] = SCF_CMD_CHALLENGE;
      xfer(1'b0, 1);
      check(addr_ack, 1'b0);
      dev_sleep = 1'b0;
      xfer(1'b0, 1);
      check(addr_ack, 1'b0);
      @(negedge clk);
      dev_sleep = 1'b1;
      host_sleep = 1'b1;
      repeat (8) @(negedge clk);
      dev_sleep = 1'b0;
      host_sleep = 1'b0;
      rel = cyc;
      xfer(1'b0, 1);
      check(take - rel >= WK, 1'b1);
      check(addr_ack, 1'b1);
      $display("Test sleep done");
   endtask : t_sleep
   task automatic t_penalty;
      wq[0] = SCF_CMD_PENALTY;
      xfer(1'b0, 1);
      check(addr_ack, 1'b1);
      do_reset(1'b1);
      wait_ready(PEN);
      do_reset(1'b0);
      wait_ready(RDY);
      $display("Test penalty done");
   endtask : t_penalty
   initial begin
      t_power_up();
      t_derive();
      t_challenge();
      t_counter();
      t_sleep();
      t_penalty();
      conclude();
   end
endmodule : tb
